/* common/bscan_regs.svh */
// Functional notes
// - bypass, boundary and identification registers present
// - identification: 32-bit shift plus parallel latch
// - identification selected by instruction or reset
// - revision top nibble, device code below
// - manufacturer code bits 11:1, bit0 one
// - one-bit bypass for bypass/clamp/highz
// - bypass forms single stage serial path
// - boundary register shift path plus parallel latch
// - 3-bit instruction, identify 001, bypass 111
// - identification word loaded at capture edge
`ifndef BSCAN_REGS_SVH
`define BSCAN_REGS_SVH
`define IR_W        3
`define IR_EXTEST   3'h0
`define IR_IDCODE   3'h1
`define IR_SAMPLE   3'h2
`define IR_CLAMP    3'h3
`define IR_HIGHZ    3'h4
`define IR_BYPASS   3'h7
`define IR_CAPTURE  3'h1
`define ID_W        32
`define ID_REV_HI   31
`define ID_REV_LO   28
`define ID_DEV_HI   27
`define ID_DEV_LO   12
`define ID_MFG_HI   11
`define ID_MFG_LO   1
`define ID_ONE_BIT  0
`define ID_ONE      1'b1
`define BYP_CAPTURE 1'b0
`endif

/* common/bscan_pkg.sv */
package bscan_pkg;
    typedef enum logic [15:0] {
        st_reset  = 16'h0001,
        st_idle   = 16'h0002,
        st_sel_dr = 16'h0004,
        st_cap_dr = 16'h0008,
        st_sh_dr  = 16'h0010,
        st_ex1_dr = 16'h0020,
        st_pa_dr  = 16'h0040,
        st_ex2_dr = 16'h0080,
        st_up_dr  = 16'h0100,
        st_sel_ir = 16'h0200,
        st_cap_ir = 16'h0400,
        st_sh_ir  = 16'h0800,
        st_ex1_ir = 16'h1000,
        st_pa_ir  = 16'h2000,
        st_ex2_ir = 16'h4000,
        st_up_ir  = 16'h8000
    } tap_state_e;
endpackage

/* rtl/boundary_scan_test_registers.sv */
`timescale 1ns/1ns
`include "bscan_regs.svh"
module boundary_scan_test_registers #(
    parameter int         BSR_LEN     = 8,
    parameter logic [3:0]  REVISION    = 4'h0,
    parameter logic [15:0] DEVICE_CODE = 16'h5A5A, // arbitrary value
    parameter logic [10:0] MFG_CODE    = 11'h2A5   // arbitrary value
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               test_port_clock,
    input  wire logic               test_mode_select,
    input  wire logic               test_serial_in,
    output      logic               test_serial_out,
    output      logic               test_serial_out_en,
    input  wire logic [BSR_LEN-1:0] bsr_pin_in,
    output      logic [BSR_LEN-1:0] bsr_par_out,
    output      logic               pin_test_drive,
    output      logic               pin_highz
);
    import bscan_pkg::*;

    tap_state_e state_r, state_nxt;
    logic [`IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic             byp_r, byp_nxt;
    logic [`ID_W-1:0] id_sh_r, id_sh_nxt, id_par_r, id_par_nxt, id_word;
    logic [BSR_LEN-1:0] bsr_sh_r, bsr_sh_nxt, bsr_par_r, bsr_par_nxt;
    logic [BSR_LEN-1:0] pin_s1_r, pin_s2_r;
    logic             tdo_r, tdo_nxt, tdo_en_r, tdo_en_nxt;
    logic             upd_tgl_r, upd_tgl_nxt;
    logic             drv_req_r, drv_req_nxt, hz_req_r, hz_req_nxt;
    logic             sel_id, sel_byp, sel_bsr;

    always_comb begin
        id_word = '0;
        id_word[`ID_REV_HI:`ID_REV_LO] = REVISION;
        id_word[`ID_DEV_HI:`ID_DEV_LO] = DEVICE_CODE;
        id_word[`ID_MFG_HI:`ID_MFG_LO] = MFG_CODE;
        id_word[`ID_ONE_BIT]           = `ID_ONE;
    end

    // register select; unknown codes fall to bypass as a safe path
    always_comb begin
        sel_id  = (ir_r == `IR_IDCODE);
        sel_bsr = (ir_r == `IR_EXTEST) || (ir_r == `IR_SAMPLE);
        sel_byp = !sel_id && !sel_bsr;
    end

    // tap sequencing
    always_comb begin
        case (state_r)
            st_reset:  state_nxt = test_mode_select ? st_reset  : st_idle;
            st_idle:   state_nxt = test_mode_select ? st_sel_dr : st_idle;
            st_sel_dr: state_nxt = test_mode_select ? st_sel_ir : st_cap_dr;
            st_cap_dr: state_nxt = test_mode_select ? st_ex1_dr : st_sh_dr;
            st_sh_dr:  state_nxt = test_mode_select ? st_ex1_dr : st_sh_dr;
            st_ex1_dr: state_nxt = test_mode_select ? st_up_dr  : st_pa_dr;
            st_pa_dr:  state_nxt = test_mode_select ? st_ex2_dr : st_pa_dr;
            st_ex2_dr: state_nxt = test_mode_select ? st_up_dr  : st_sh_dr;
            st_up_dr:  state_nxt = test_mode_select ? st_sel_dr : st_idle;
            st_sel_ir: state_nxt = test_mode_select ? st_reset  : st_cap_ir;
            st_cap_ir: state_nxt = test_mode_select ? st_ex1_ir : st_sh_ir;
            st_sh_ir:  state_nxt = test_mode_select ? st_ex1_ir : st_sh_ir;
            st_ex1_ir: state_nxt = test_mode_select ? st_up_ir  : st_pa_ir;
            st_pa_ir:  state_nxt = test_mode_select ? st_ex2_ir : st_pa_ir;
            st_ex2_ir: state_nxt = test_mode_select ? st_up_ir  : st_sh_ir;
            st_up_ir:  state_nxt = test_mode_select ? st_sel_dr : st_idle;
            default:   state_nxt = st_reset;
        endcase
    end

    // shift stages, rising test clock
    always_comb begin
        ir_sh_nxt  = ir_sh_r;
        byp_nxt    = byp_r;
        id_sh_nxt  = id_sh_r;
        bsr_sh_nxt = bsr_sh_r;
        if (state_r == st_cap_ir) begin
            ir_sh_nxt = `IR_CAPTURE;
        end else if (state_r == st_sh_ir) begin
            ir_sh_nxt = {test_serial_in, ir_sh_r[`IR_W-1:1]};
        end
        if (state_r == st_cap_dr) begin
            if (sel_byp) begin
                byp_nxt = `BYP_CAPTURE;
            end
            if (sel_id) begin
                id_sh_nxt = id_word;
            end
            if (sel_bsr) begin
                bsr_sh_nxt = pin_s2_r;
            end
        end else if (state_r == st_sh_dr) begin
            if (sel_byp) begin
                byp_nxt = test_serial_in;
            end
            if (sel_id) begin
                id_sh_nxt = {test_serial_in, id_sh_r[`ID_W-1:1]};
            end
            if (sel_bsr) begin
                bsr_sh_nxt = {test_serial_in, bsr_sh_r[BSR_LEN-1:1]};
            end
        end
    end

    // pins come from the system domain, so two stages on the test clock
    always_ff @(posedge test_port_clock or negedge nrst) begin
        if (!nrst) begin
            state_r  <= st_reset;
            ir_sh_r  <= '0;
            byp_r    <= 1'b0;
            id_sh_r  <= '0;
            bsr_sh_r <= '0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            state_r  <= state_nxt;
            ir_sh_r  <= ir_sh_nxt;
            byp_r    <= byp_nxt;
            id_sh_r  <= id_sh_nxt;
            bsr_sh_r <= bsr_sh_nxt;
            pin_s1_r <= bsr_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // latches and serial output, falling test clock
    always_comb begin
        ir_nxt      = ir_r;
        id_par_nxt  = id_par_r;
        bsr_par_nxt = bsr_par_r;
        upd_tgl_nxt = upd_tgl_r;
        tdo_nxt     = tdo_r;
        tdo_en_nxt  = (state_r == st_sh_ir) || (state_r == st_sh_dr);
        if (state_r == st_reset) begin
            ir_nxt = `IR_IDCODE;
        end else if (state_r == st_up_ir) begin
            ir_nxt = ir_sh_r;
        end
        // decoded here so the synchroniser never sees a multi-bit decode glitch
        drv_req_nxt = (ir_nxt == `IR_EXTEST) || (ir_nxt == `IR_CLAMP);
        hz_req_nxt  = (ir_nxt == `IR_HIGHZ);
        if (state_r == st_up_dr) begin
            if (sel_id) begin
                id_par_nxt = id_sh_r;
            end
            if (sel_bsr) begin
                bsr_par_nxt = bsr_sh_r;
                upd_tgl_nxt = !upd_tgl_r;
            end
        end
        if (state_r == st_sh_ir) begin
            tdo_nxt = ir_sh_r[0];
        end else if (state_r == st_sh_dr) begin
            tdo_nxt = sel_id ? id_sh_r[0] : (sel_bsr ? bsr_sh_r[0] : byp_r);
        end
    end

    always_ff @(negedge test_port_clock or negedge nrst) begin
        if (!nrst) begin
            ir_r      <= `IR_IDCODE;
            id_par_r  <= '0;
            bsr_par_r <= '0;
            upd_tgl_r <= 1'b0;
            tdo_r     <= 1'b0;
            tdo_en_r  <= 1'b0;
            drv_req_r <= 1'b0;
            hz_req_r  <= 1'b0;
        end else begin
            ir_r      <= ir_nxt;
            id_par_r  <= id_par_nxt;
            bsr_par_r <= bsr_par_nxt;
            upd_tgl_r <= upd_tgl_nxt;
            tdo_r     <= tdo_nxt;
            tdo_en_r  <= tdo_en_nxt;
            drv_req_r <= drv_req_nxt;
            hz_req_r  <= hz_req_nxt;
        end
    end

    assign test_serial_out    = tdo_r;
    assign test_serial_out_en = tdo_en_r;

    // system side: the word is stable long before the toggle lands, so it is taken whole
    logic [2:0]         tgl_sync_r, tgl_sync_nxt;
    logic [1:0]         drv_sync_r, drv_sync_nxt, hz_sync_r, hz_sync_nxt;
    logic [BSR_LEN-1:0] out_r, out_nxt;
    always_comb begin
        tgl_sync_nxt = {tgl_sync_r[1:0], upd_tgl_r};
        drv_sync_nxt = {drv_sync_r[0], drv_req_r};
        hz_sync_nxt  = {hz_sync_r[0], hz_req_r};
        out_nxt      = (tgl_sync_r[2] != tgl_sync_r[1]) ? bsr_par_r : out_r;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tgl_sync_r <= '0;
            drv_sync_r <= '0;
            hz_sync_r  <= '0;
            out_r      <= '0;
        end else begin
            tgl_sync_r <= tgl_sync_nxt;
            drv_sync_r <= drv_sync_nxt;
            hz_sync_r  <= hz_sync_nxt;
            out_r      <= out_nxt;
        end
    end
    assign bsr_par_out    = out_r;
    assign pin_test_drive = drv_sync_r[1];
    assign pin_highz      = hz_sync_r[1];

    default clocking cb @(posedge test_port_clock); endclocking
    default disable iff (!nrst);

    sequence s_id_capture;
        (state_r == st_cap_dr) && sel_id;
    endsequence
    property p_one_select;
        (state_r == st_sh_dr) |-> test_serial_out_en
            && (test_serial_out == (sel_id ? id_sh_r[0] : (sel_bsr ? bsr_sh_r[0] : byp_r)));
    endproperty
    a_one_select: assert property (p_one_select) else $error("wrong serial source");
    property p_id_fields;
        s_id_capture |=> (id_sh_r[`ID_REV_HI:`ID_REV_LO] == REVISION)
            && (id_sh_r[`ID_DEV_HI:`ID_DEV_LO] == DEVICE_CODE);
    endproperty
    a_id_fields: assert property (p_id_fields) else $error("id upper fields wrong");
    property p_id_low;
        s_id_capture |=> id_sh_r[`ID_ONE_BIT] && (id_sh_r[`ID_MFG_HI:`ID_MFG_LO] == MFG_CODE);
    endproperty
    a_id_low: assert property (p_id_low) else $error("id low fields wrong");
    property p_id_load;
        s_id_capture ##1 (state_r == st_sh_dr) |=> id_sh_r[`ID_W-2:0] == id_word[`ID_W-1:1];
    endproperty
    a_id_load: assert property (p_id_load) else $error("id not loaded then shifted");
    property p_id_latch;
        (state_r == st_up_dr) && sel_id |=> id_par_r == $past(id_sh_r);
    endproperty
    a_id_latch: assert property (p_id_latch) else $error("id latch missed");
    property p_reset_id;
        (state_r == st_reset) |=> sel_id;
    endproperty
    a_reset_id: assert property (p_reset_id) else $error("reset not selecting id");
    property p_byp_zero;
        (state_r == st_cap_dr) && sel_byp |=> !byp_r;
    endproperty
    a_byp_zero: assert property (p_byp_zero) else $error("bypass capture not zero");
    property p_byp_path;
        (state_r == st_sh_dr) && sel_byp |=> byp_r == $past(test_serial_in);
    endproperty
    a_byp_path: assert property (p_byp_path) else $error("bypass path broken");
    property p_byp_sel;
        (ir_r == `IR_CLAMP) || (ir_r == `IR_HIGHZ) || (ir_r == `IR_BYPASS) |-> sel_byp;
    endproperty
    a_byp_sel: assert property (p_byp_sel) else $error("bypass not selected");
    property p_bsr_latch;
        (state_r == st_up_dr) && sel_bsr |=> bsr_par_r == $past(bsr_sh_r);
    endproperty
    a_bsr_latch: assert property (p_bsr_latch) else $error("boundary latch missed");
    property p_ir_latch;
        (state_r == st_up_ir) |=> ir_r == $past(ir_sh_r);
    endproperty
    a_ir_latch: assert property (p_ir_latch) else $error("instruction latch missed");
endmodule

/* bench/tap_tester.sv */
`timescale 1ns/1ns
module tap_tester (
    output logic test_port_clock,
    output logic test_mode_select,
    output logic test_serial_in,
    input  wire logic test_serial_out
);
    // test clock only runs inside frames, rests low between them
    // mode select and data are first set by the reset walk, so nothing races it
    initial begin
        test_port_clock = 1'b0;
    end

    // inputs change at the falling edge, output sampled just before the rising edge
    task automatic tick(input logic m, input logic d, output logic o);
        test_mode_select = m;
        test_serial_in = d;
        #40;
        o = test_serial_out;
        test_port_clock = 1'b1;
        #40;
        test_port_clock = 1'b0;
    endtask

    // five mode-select highs reach logic reset, then park in idle
    task automatic go_reset();
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b1, o);
    endtask

    // idle -> shift-IR, lsb first, update, back to idle
    task automatic shift_ir(input logic [2:0] c);
        logic o;
        tick(1'b1, ~test_serial_in, o);
        tick(1'b1, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
        for (int i = 0; i < 3; i++) begin
            tick(i == 2, c[i], o);
        end
        tick(1'b1, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
    endtask

    // idle -> capture-DR -> shift n bits lsb first -> update -> idle
    task automatic shift_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic o;
        dout = 32'h0000_0000;
        tick(1'b1, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, ~test_serial_in, o);
        tick(1'b0, ~test_serial_in, o);
    endtask
endmodule

/* bench/tb_boundary_scan_test_registers.sv */
`timescale 1ns/1ns
`include "bscan_regs.svh"
module tb_boundary_scan_test_registers;
    localparam int          N   = 8;
    localparam logic [3:0]  REV = 4'hC;     // arbitrary value
    localparam logic [15:0] DEV = 16'h1234; // arbitrary value
    localparam logic [10:0] MFG = 11'h3C5;  // arbitrary value
    localparam logic [31:0] ID_EXP = {REV, DEV, MFG, `ID_ONE};

    logic         clk;
    logic         nrst;
    wire logic    tck;
    wire logic    tms;
    wire logic    tdi;
    logic         tdo;
    logic         tdo_en;
    logic [N-1:0] pin_in;
    logic [N-1:0] par_out;
    logic         drv;
    logic         hz;
    int           miscompares;
    int           n_checks;

    boundary_scan_test_registers #(.BSR_LEN(N), .REVISION(REV), .DEVICE_CODE(DEV),
        .MFG_CODE(MFG)) u_boundary_scan_test_registers (
        .clk(clk), .nrst(nrst), .test_port_clock(tck), .test_mode_select(tms),
        .test_serial_in(tdi), .test_serial_out(tdo), .test_serial_out_en(tdo_en),
        .bsr_pin_in(pin_in), .bsr_par_out(par_out), .pin_test_drive(drv), .pin_highz(hz));

    tap_tester u_tap_tester (.test_port_clock(tck), .test_mode_select(tms),
        .test_serial_in(tdi), .test_serial_out(tdo));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // clk-domain copies lag the test clock by a few cycles
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_id();
        logic [31:0] d;
        u_tap_tester.go_reset();
        u_tap_tester.shift_dr(32'h0000_0000, 32, d);
        check("id after reset", ID_EXP, d);
        check("out enable idle", 32'h0000_0000, {31'h0, tdo_en});
    endtask

    // every bypass-selecting code, unknown ones too; capture bit comes out first
    task automatic t_bypass();
        logic [2:0]  codes [5] = '{`IR_BYPASS, `IR_CLAMP, `IR_HIGHZ, 3'h5, 3'h6};
        logic [31:0] d;
        foreach (codes[k]) begin
            u_tap_tester.shift_ir(codes[k]);
            u_tap_tester.shift_dr(32'h0000_00A5, 8, d);
            check("bypass path", 32'h0000_004A, d);
            settle();
            check("test drive", {31'h0, codes[k] == `IR_CLAMP}, {31'h0, drv});
            check("high z", {31'h0, codes[k] == `IR_HIGHZ}, {31'h0, hz});
        end
    endtask

    task automatic t_id_instr();
        logic [31:0] d;
        u_tap_tester.shift_ir(`IR_IDCODE);
        u_tap_tester.shift_dr(32'h0000_0000, 32, d);
        check("id by instruction", ID_EXP, d);
        u_tap_tester.shift_dr(32'hFFFF_0000, 32, d);
        check("id recaptured", ID_EXP, d);
    endtask

    task automatic t_boundary();
        logic [31:0] d;
        @(posedge clk);
        pin_in <= 8'h96;
        u_tap_tester.shift_ir(`IR_SAMPLE);
        u_tap_tester.shift_dr(32'h0000_003C, N, d);
        check("sample capture", 32'h0000_0096, d);
        settle();
        check("parallel latch", 32'h0000_003C, {24'h0, par_out});
        check("no drive sample", 32'h0000_0000, {31'h0, drv});
        u_tap_tester.shift_ir(`IR_EXTEST);
        settle();
        check("drive extest", 32'h0000_0001, {31'h0, drv});
        check("latch held", 32'h0000_003C, {24'h0, par_out});
        @(posedge clk);
        pin_in <= 8'h69;
        u_tap_tester.shift_dr(32'h0000_005A, N, d);
        check("extest capture", 32'h0000_0069, d);
        settle();
        check("latch updated", 32'h0000_005A, {24'h0, par_out});
    endtask

    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        miscompares = 0;
        n_checks = 0;
        nrst = 1'b0;
        pin_in = '0;
        fork
            u_tap_tester.go_reset();
            repeat (20) @(posedge clk);
        join
        nrst <= 1'b1;
        @(posedge clk);
        t_reset_id();
        t_bypass();
        t_id_instr();
        u_tap_tester.shift_ir(`IR_BYPASS);
        t_reset_id();
        t_boundary();
        complete_run();
    end
endmodule
